// >>> sbe_consts.svh
// constants for the status word / operand formatting block
// assumes a 32-bit data path and an AXI4-Lite register port
`ifndef SBE_CONSTS_SVH
`define SBE_CONSTS_SVH

// register byte offsets
`define SBE_PSW_OFS 8'h00
`define SBE_MODE_OFS 8'h04
`define SBE_ERRADR_OFS 8'h08

// status word field positions
`define SBE_PSW_MD 30
`define SBE_PSW_RB 29
`define SBE_PSW_BL 28
`define SBE_PSW_M 9
`define SBE_PSW_Q 8
`define SBE_PSW_I_HI 7
`define SBE_PSW_I_LO 4
`define SBE_PSW_S 1
`define SBE_PSW_T 0

// write masks: all assigned bits, and the bits open to user mode
`define SBE_PSW_PRIV_MASK 32'h700003f3
`define SBE_PSW_USER_MASK 32'h00000303

// reset values
`define SBE_IMASK_RST 4'hf
`define SBE_FLAG_RST 1'h1

// mode/status register fields
`define SBE_MODE_LE 0
`define SBE_MODE_ERR 1

// axi responses
`define SBE_RESP_OKAY 2'h0
`define SBE_RESP_SLVERR 2'h2

`endif

// >>> sbe_pkg.sv
// types shared by the status word / operand formatting block
// assumes nothing beyond a SystemVerilog elaborator
package sbe_pkg;
  typedef enum logic [1:0] {
    SBE_SZ_BYTE = 2'h0,
    SBE_SZ_WORD = 2'h1,
    SBE_SZ_LONG = 2'h2
  } sbe_size_e;
endpackage

// >>> sbe_bank_map.sv
// general register index to physical register file index
// assumes bank select comes from the status word owner
`timescale 1ns/10ps
module sbe_bank_map
  import sbe_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] gpr_index,
  input wire logic ctrl_move,
  input wire logic bank_select_flag,
  output logic [4:0] gpr_phys_index
);
  // physical 0-7 bank zero, 8-15 common, 16-23 bank one
  logic bank;

  // (RL3) bank swap decode
  always_comb begin
    bank = bank_select_flag ^ ctrl_move;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gpr_phys_index <= 5'h00;
    end else if (gpr_index[3]) begin
      gpr_phys_index <= {1'b0, gpr_index};
    end else begin
      gpr_phys_index <= {bank, 1'b0, gpr_index[2:0]};
    end
  end
endmodule // sbe_bank_map

// >>> sbe_load_fmt.sv
// memory operand formatting: alignment check, lane pick, sign extension
// assumes memory returns the aligned longword holding the operand
`timescale 1ns/10ps
module sbe_load_fmt
  import sbe_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic little_endian,
  output logic ld_valid,
  output logic [31:0] ld_data,
  output logic addr_error
);
  function automatic logic [31:0] sext8(input logic [7:0] b);
    sext8 = {{24{b[7]}}, b};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] h);
    sext16 = {{16{h[15]}}, h};
  endfunction

  logic misaligned;
  logic [1:0] lane;
  logic [31:0] fmt;

  always_comb begin
    // (RL14) alignment check
    unique case (req_size)
      SBE_SZ_WORD: misaligned = req_addr[0];
      SBE_SZ_LONG: misaligned = |req_addr[1:0];
      default: misaligned = 1'b0;
    endcase
    // big-endian puts the lowest address in bits 31:24
    lane = little_endian ? req_addr[1:0] : ~req_addr[1:0];
    // (RL13) sign-extend short operands
    unique case (req_size)
      SBE_SZ_BYTE: fmt = sext8(mem_rdata[8*lane +: 8]);
      SBE_SZ_WORD: fmt = sext16(lane[1] ? mem_rdata[31:16] : mem_rdata[15:0]);
      default: fmt = mem_rdata;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ld_valid <= 1'b0;
      ld_data <= 32'h00000000;
      addr_error <= 1'b0;
    end else begin
      ld_valid <= req_valid && !misaligned;
      addr_error <= req_valid && misaligned;
      if (req_valid && !misaligned) begin
        ld_data <= fmt;
      end
    end
  end
endmodule // sbe_load_fmt

// >>> sbe_top.sv
// status word, bank select, operand formatting and endian strap for a 32-bit core
// assumes an AXI4-Lite master for software access and a core that drives the
// exception request, flag update and load ports synchronously to clock
`timescale 1ns/10ps
`include "sbe_consts.svh"

// What this block does
// (RL1) privilege flag one means privileged operation, zero means user operation
// (RL2) privilege flag forced to one on exception entry and on reset
// (RL3) bank flag picks which bank registers 0-7 use; 8-15 never banked
// (RL4) bank flag set to one on exception entry and on reset
// (RL5) event hold flag at one blocks exception and interrupt acceptance
// (RL6) event hold flag set to one on exception entry and on reset
// (RL7) four-bit mask level resets to all ones, unchanged on interrupt entry
// (RL8) condition flag records compare truth or arithmetic carry and overflow
// (RL9) two divide flags serve divide steps, clamp flag steers multiply-accumulate
// (RL10) unassigned status bits read zero; software writes zero there
// (RL11) divide, clamp and condition flags writable in user mode; reset value undefined
// (RL12) all other status bits accessible only in privileged mode
// (RL13) registers 32 bits; byte and word loads sign-extended
// (RL14) word needs even address, longword multiple of four, else address error
// (RL15) byte order caught from strap at power-on reset, low big, high little
// (RL16) bit 31 is most significant, bit 0 least significant
// (RL17) little-endian software reads back with the size it wrote
module sbe_top
  import sbe_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic rst_is_power_on,
  input wire logic endian_strap_pin,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // exception entry
  input wire logic exc_req,
  output logic exc_accept,
  // flag updates from the execution unit: {m, q, s, t}
  input wire logic [3:0] flag_we,
  input wire logic [3:0] flag_wdata,
  // status word fields
  output logic privilege_level_flag,
  output logic bank_select_flag,
  output logic event_hold_flag,
  output logic [3:0] irq_mask_level,
  output logic divide_m_flag,
  output logic divide_q_flag,
  output logic clamp_flag,
  output logic cond_flag,
  // register bank mapping
  input wire logic [3:0] gpr_index,
  input wire logic ctrl_move,
  output logic [4:0] gpr_phys_index,
  // memory operand formatting
  input wire logic mem_req_valid,
  input wire logic [1:0] mem_req_size,
  input wire logic [31:0] mem_req_addr,
  input wire logic [31:0] mem_rdata,
  output logic ld_valid,
  output logic [31:0] ld_data,
  output logic addr_error,
  output logic little_endian
);
  // merges byte lanes of a write under its strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge_strb = r;
  endfunction

  logic md_q, rb_q, bl_q;
  logic [3:0] imask_q;
  logic m_q, q_q, s_q, t_q;
  logic le_q;
  logic err_seen_q;
  logic [31:0] err_addr_q;
  logic [31:0] req_addr_q;

  logic aw_hold_q, w_hold_q, bvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic wr_fire;
  logic psw_wr, mode_wr;
  logic [31:0] psw_cur, psw_wmask, psw_new, psw_view, mode_cur, mode_new;
  logic [31:0] rd_val;
  logic rd_hit;
  logic exc_take;

  // register word indices cut to the width of the address word field
  localparam logic [ADDR_W-3:0] PSW_IDX = (ADDR_W-2)'(`SBE_PSW_OFS >> 2);
  localparam logic [ADDR_W-3:0] MODE_IDX = (ADDR_W-2)'(`SBE_MODE_OFS >> 2);
  localparam logic [ADDR_W-3:0] ERRADR_IDX = (ADDR_W-2)'(`SBE_ERRADR_OFS >> 2);

  // (RL5) hold flag gates acceptance
  assign exc_take = exc_req && !bl_q;
  assign exc_accept = exc_take;

  // (RL10) unassigned bits held at zero
  always_comb begin
    psw_cur = 32'h00000000;
    psw_cur[`SBE_PSW_MD] = md_q;
    psw_cur[`SBE_PSW_RB] = rb_q;
    psw_cur[`SBE_PSW_BL] = bl_q;
    psw_cur[`SBE_PSW_M] = m_q;
    psw_cur[`SBE_PSW_Q] = q_q;
    psw_cur[`SBE_PSW_I_HI:`SBE_PSW_I_LO] = imask_q;
    psw_cur[`SBE_PSW_S] = s_q;
    psw_cur[`SBE_PSW_T] = t_q;
  end

  // (RL12) user mode sees and alters only the four flags
  always_comb begin
    psw_wmask = md_q ? `SBE_PSW_PRIV_MASK : `SBE_PSW_USER_MASK;
    psw_view = psw_cur & psw_wmask;
    psw_new = (merge_strb(psw_cur, wdata_q, wstrb_q) & psw_wmask) | (psw_cur & ~psw_wmask);
  end

  always_comb begin
    mode_cur = 32'h00000000;
    mode_cur[`SBE_MODE_LE] = le_q;
    mode_cur[`SBE_MODE_ERR] = err_seen_q;
    mode_new = merge_strb(32'h00000000, wdata_q, wstrb_q);
  end

  // write channel: address and data taken in either order, then one response
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign psw_wr = wr_fire && (awaddr_q[ADDR_W-1:2] == PSW_IDX);
  assign mode_wr = wr_fire && (awaddr_q[ADDR_W-1:2] == MODE_IDX);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `SBE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      // error address register is read-only, so writes there are refused too
      bresp_q <= (psw_wr || mode_wr) ? `SBE_RESP_OKAY : `SBE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel: one read at a time, data registered
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[ADDR_W-1:2])
      PSW_IDX: rd_val = psw_view;
      MODE_IDX: rd_val = mode_cur;
      ERRADR_IDX: rd_val = err_addr_q;
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SBE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `SBE_RESP_OKAY : `SBE_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // privileged control fields; exception entry beats a software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // (RL2) reset value one
      md_q <= `SBE_FLAG_RST;
      // (RL4) reset value one
      rb_q <= `SBE_FLAG_RST;
      // (RL6) reset value one
      bl_q <= `SBE_FLAG_RST;
      // (RL7) mask all ones
      imask_q <= `SBE_IMASK_RST;
    end else if (exc_take) begin
      // (RL2) entry forces privilege
      md_q <= 1'b1;
      // (RL4) entry forces bank
      rb_q <= 1'b1;
      // (RL6) entry forces hold
      bl_q <= 1'b1;
      // (RL7) mask left alone on entry
    end else if (psw_wr) begin
      // (RL1) privilege flag update
      md_q <= psw_new[`SBE_PSW_MD];
      rb_q <= psw_new[`SBE_PSW_RB];
      bl_q <= psw_new[`SBE_PSW_BL];
      imask_q <= psw_new[`SBE_PSW_I_HI:`SBE_PSW_I_LO];
    end
  end

  // (RL11) user-writable flags; execution unit wins over software per bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // held at zero so simulation never carries unknowns
      m_q <= 1'b0;
      q_q <= 1'b0;
      s_q <= 1'b0;
      t_q <= 1'b0;
    end else begin
      // (RL9) divide and clamp flags
      if (flag_we[3]) begin
        m_q <= flag_wdata[3];
      end else if (psw_wr) begin
        m_q <= psw_new[`SBE_PSW_M];
      end
      if (flag_we[2]) begin
        q_q <= flag_wdata[2];
      end else if (psw_wr) begin
        q_q <= psw_new[`SBE_PSW_Q];
      end
      if (flag_we[1]) begin
        s_q <= flag_wdata[1];
      end else if (psw_wr) begin
        s_q <= psw_new[`SBE_PSW_S];
      end
      // (RL8) condition flag update
      if (flag_we[0]) begin
        t_q <= flag_wdata[0];
      end else if (psw_wr) begin
        t_q <= psw_new[`SBE_PSW_T];
      end
    end
  end

  // (RL15) strap sampled while power-on reset is held; other resets keep it
  always_ff @(posedge clock) begin
    if (rst && rst_is_power_on) begin
      le_q <= endian_strap_pin;
    end
  end

  // sticky address error record, write one to clear; a new error wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_seen_q <= 1'b0;
      err_addr_q <= 32'h00000000;
    end else if (addr_error) begin
      err_seen_q <= 1'b1;
      err_addr_q <= req_addr_q;
    end else if (mode_wr && mode_new[`SBE_MODE_ERR]) begin
      err_seen_q <= 1'b0;
    end
  end

  // the formatter reports one cycle late, so the address is held alongside
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_addr_q <= 32'h00000000;
    end else if (mem_req_valid) begin
      req_addr_q <= mem_req_addr;
    end
  end

  assign privilege_level_flag = md_q;
  assign bank_select_flag = rb_q;
  assign event_hold_flag = bl_q;
  assign irq_mask_level = imask_q;
  assign divide_m_flag = m_q;
  assign divide_q_flag = q_q;
  assign clamp_flag = s_q;
  assign cond_flag = t_q;
  assign little_endian = le_q;

  // (RL3) bank mapping
  sbe_bank_map u_bank_map (
    .clock(clock),
    .rst(rst),
    .gpr_index(gpr_index),
    .ctrl_move(ctrl_move),
    .bank_select_flag(rb_q),
    .gpr_phys_index(gpr_phys_index)
  );

  // (RL13) (RL14) (RL16) operand formatting
  sbe_load_fmt u_load_fmt (
    .clock(clock),
    .rst(rst),
    .req_valid(mem_req_valid),
    .req_size(mem_req_size),
    .req_addr(mem_req_addr),
    .mem_rdata(mem_rdata),
    .little_endian(le_q),
    .ld_valid(ld_valid),
    .ld_data(ld_data),
    .addr_error(addr_error)
  );
endmodule // sbe_top

// >>> sbe_top_checker.sv
// assertions on status flags, exception entry, bank map and load formatting
// assumes binding to sbe_top, one clock domain
`timescale 1ns/10ps
module sbe_top_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic exc_req,
  input wire logic exc_accept,
  input wire logic privilege_level_flag,
  input wire logic bank_select_flag,
  input wire logic event_hold_flag,
  input wire logic [3:0] irq_mask_level,
  input wire logic [3:0] gpr_index,
  input wire logic ctrl_move,
  input wire logic [4:0] gpr_phys_index,
  input wire logic mem_req_valid,
  input wire logic [1:0] mem_req_size,
  input wire logic [31:0] mem_req_addr,
  input wire logic ld_valid,
  input wire logic addr_error,
  input wire logic little_endian
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic mis;
  assign mis = (mem_req_size == 2'h1 && mem_req_addr[0]) || (mem_req_size == 2'h2 && mem_req_addr[1:0] != 2'h0);
  chk_entry_flags:
    assert property (exc_accept |=> privilege_level_flag && bank_select_flag && event_hold_flag) else $error("entry flag");
  chk_hold_gate:
    assert property (exc_accept == (exc_req && !event_hold_flag)) else $error("hold gate");
  chk_mask_kept:
    assert property (exc_accept |=> $stable(irq_mask_level)) else $error("mask moved");
  chk_reset_vals:
    assert property ($fell(rst) |-> privilege_level_flag && bank_select_flag && event_hold_flag
      && irq_mask_level == 4'hf) else $error("reset flags");
  chk_load_one:
    assert property (mem_req_valid |=> ld_valid != addr_error) else $error("load answer");
  chk_misalign:
    assert property (mem_req_valid && mis |=> addr_error) else $error("no addr error");
  chk_byte_any:
    assert property (mem_req_valid && mem_req_size == 2'h0 |=> ld_valid) else $error("byte refused");
  chk_bank_high:
    assert property (gpr_index[3] |=> gpr_phys_index == {1'b0, $past(gpr_index)}) else $error("high bank");
  chk_bank_low:
    assert property (!gpr_index[3] |=> gpr_phys_index == {$past(bank_select_flag ^ ctrl_move), 1'b0,
      $past(gpr_index[2:0])}) else $error("low bank");
  chk_endian_fix:
    assert property (!$past(rst) |-> $stable(little_endian)) else $error("endian moved");
  cover property (exc_accept);
  cover property (mem_req_valid && mis);
  cover property (ctrl_move && !gpr_index[3]);
endmodule // sbe_top_checker

bind sbe_top sbe_top_checker i_chk (.clock, .rst, .exc_req, .exc_accept, .privilege_level_flag, .bank_select_flag,
  .event_hold_flag, .irq_mask_level, .gpr_index, .ctrl_move, .gpr_phys_index, .mem_req_valid, .mem_req_size,
  .mem_req_addr, .ld_valid, .addr_error, .little_endian);

// >>> sbe_mem_model.sv
// memory model answering load requests with the aligned longword
// assumes the bench preloads words before issuing loads
`timescale 1ns/10ps
module sbe_mem_model (
  input wire logic clock,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  output logic [31:0] rdata
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    last_q <= rdata;
  end
  // whole longword answer
  // idle bus toggles so a stale value never passes for data
  assign rdata = req_valid ? mem[req_addr[5:2]] : ~last_q;
endmodule // sbe_mem_model

// >>> status_bank_endian_ctrl_bench.sv
// self-checking bench: register access, exception entry, bank map, loads, endian strap
// assumes sbe_top, sbe_mem_model and the bound checker are compiled first
`timescale 1ns/10ps
module status_bank_endian_ctrl_bench;
  logic clock, rst, rst_is_power_on, endian_strap_pin, exc_req, ctrl_move, mem_req_valid, wr_en, le;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, exc_accept, privilege_level_flag, bank_select_flag;
  logic event_hold_flag, divide_m_flag, divide_q_flag, clamp_flag, cond_flag, ld_valid, addr_error, little_endian;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, mem_req_addr, mem_rdata, ld_data, s_axi_rdata, wr_data, seed, last_bad;
  logic [3:0] s_axi_wstrb, flag_we, flag_wdata, gpr_index, irq_mask_level, wr_idx;
  logic [1:0] mem_req_size, s_axi_bresp, s_axi_rresp;
  logic [4:0] gpr_phys_index;
  logic [31:0] img [16];
  logic [32:0] exp_q [$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  sbe_top #(.ADDR_W(8)) i_dut (.clock, .rst, .rst_is_power_on, .endian_strap_pin, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .exc_req, .exc_accept, .flag_we, .flag_wdata, .privilege_level_flag, .bank_select_flag,
    .event_hold_flag, .irq_mask_level, .divide_m_flag, .divide_q_flag, .clamp_flag, .cond_flag, .gpr_index,
    .ctrl_move, .gpr_phys_index, .mem_req_valid, .mem_req_size, .mem_req_addr, .mem_rdata, .ld_valid, .ld_data,
    .addr_error, .little_endian);
  sbe_mem_model i_mem (.clock, .req_valid(mem_req_valid), .req_addr(mem_req_addr), .wr_en, .wr_idx, .wr_data,
    .rdata(mem_rdata));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // results are matched oldest first against the noted expectations
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      wrap_up();
    end
    if (!rst && (ld_valid || addr_error || (s_axi_rvalid && s_axi_rready))) begin
      chk(s_axi_rvalid ? {s_axi_rresp == 2'h2, s_axi_rdata} : {addr_error, ld_valid ? ld_data : 32'h0},
        exp_q.pop_front());
    end
  end
  task automatic do_reset(input logic p, input logic s);
    rst <= 1'b1;
    rst_is_power_on <= p;
    endian_strap_pin <= s;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, (a < 8'h08) ? 2'h0 : 2'h2);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axr(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  // mem_req_valid stays up between calls; the caller lowers it
  task automatic ld(input logic [1:0] sz, input logic [5:0] a);
    logic [31:0] w;
    logic [15:0] h;
    logic [7:0] b;
    w = img[a[5:2]];
    b = w[8 * (le ? a[1:0] : 2'h3 - a[1:0]) +: 8];
    h = w[16 * (le ? a[1] : !a[1]) +: 16];
    mem_req_valid <= 1'b1;
    mem_req_size <= sz;
    mem_req_addr <= {26'h0, a};
    if ((sz == 2'h1 && a[0]) || (sz == 2'h2 && a[1:0] != 2'h0)) begin
      exp_q.push_back({1'b1, 32'h0});
      last_bad = {26'h0, a};
    end else begin
      exp_q.push_back({1'b0, sz == 2'h0 ? {{24{b[7]}}, b} : sz == 2'h1 ? {{16{h[15]}}, h} : w});
    end
    @(posedge clock);
  endtask
  task automatic run_loads;
    for (int i = 0; i < 12; i++) begin
      ld(2'(i / 4), {seed[3:0], 2'(i)});
      seed = nxt(seed);
    end
    mem_req_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic bank_sweep(input logic rb);
    logic [4:0] e;
    repeat (16) begin
      gpr_index <= seed[3:0];
      ctrl_move <= seed[4];
      e = seed[3] ? {1'b0, seed[3:0]} : {rb ^ seed[4], 1'b0, seed[2:0]};
      seed = nxt(seed);
      @(posedge clock);
      #1;
      chk(gpr_phys_index, e);
      @(posedge clock);
    end
  endtask
  initial begin
    {rst, rst_is_power_on, endian_strap_pin, exc_req, ctrl_move, mem_req_valid, wr_en, le} = 8'h c0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_req_addr, wr_data} = 112'h0;
    {s_axi_wstrb, flag_we, flag_wdata, gpr_index, wr_idx, mem_req_size} = 22'h3c0000;
    seed = 32'he72a5193;
    do_reset(1'b1, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr_en <= 1'b1;
      wr_idx <= 4'(i);
      wr_data <= seed;
      img[i] = seed;
      seed = nxt(seed);
      @(posedge clock);
    end
    wr_en <= 1'b0;
    axr(8'h00, {1'b0, 32'h700000f0});
    axr(8'h04, {1'b0, 32'h0});
    axr(8'h0c, {1'b1, 32'h0});
    axw(8'h00, 32'h700003f3);
    axr(8'h00, {1'b0, 32'h700003f3});
    axw(8'h00, 32'h0);
    chk(privilege_level_flag, 1'b0);
    axw(8'h00, 32'h700003f3);
    axr(8'h00, {1'b0, 32'h00000303});
    flag_we <= 4'hf;
    flag_wdata <= 4'h4;
    exc_req <= 1'b1;
    @(posedge clock);
    flag_we <= 4'h0;
    #1;
    chk({privilege_level_flag, bank_select_flag, event_hold_flag, irq_mask_level, cond_flag}, 8'he0);
    chk({divide_m_flag, divide_q_flag, clamp_flag}, 3'h2);
    repeat (3) @(posedge clock);
    chk(exc_accept, 1'b0);
    exc_req <= 1'b0;
    axr(8'h00, {1'b0, 32'h70000100});
    bank_sweep(1'b1);
    axw(8'h00, 32'h50000000);
    bank_sweep(1'b0);
    run_loads();
    axr(8'h04, {1'b0, 32'h2});
    axw(8'h08, 32'h0);
    axr(8'h08, {1'b0, last_bad});
    axw(8'h04, 32'h2);
    axr(8'h04, {1'b0, 32'h0});
    do_reset(1'b1, 1'b1);
    le = 1'b1;
    axr(8'h04, {1'b0, 32'h1});
    run_loads();
    do_reset(1'b0, 1'b0);
    chk(little_endian, 1'b1);
    wrap_up();
  end
endmodule // status_bank_endian_ctrl_bench
